// ===== hdl/bmx_channel.sv
// Block multiplexer channel: subchannels, modes, instructions, cycle stealing
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
module bmx_channel
   import bmx_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Processor side
   input  wire logic        initial_program_load_i,
   output logic             hiprio_o,
   output logic             chan_avail_o,
   // Storage cycle-steal port
   output logic             st_req_o,
   output logic             st_we_o,
   output logic      [15:0] st_addr_o,
   output logic      [31:0] st_dat_o,
   input  wire logic        st_ack_i,
   input  wire logic [31:0] st_dat_i,
   // Control unit link
   input  wire bmx_link_s   link_i,
   output logic             cu_svc_o
);
   bmx_state_s q, d;
   bmx_link_s  sl;
   logic       iv, ish, rv, rsh;
   logic [5:0] iidx, ridx;
   bmx_mode_e  imode, rmode;
   logic       wr, chbusy, ins_go, ce_rise, de_rise, busy_try;
   logic [31:0] wmask;
   logic [1:0]  probe_cc;
   bmx_op_e     op;

   // ==========================================================
   // Link pins pass the synchroniser
   // 3-bit unit field
   bmx_sync3 #(.W($bits(bmx_link_s))) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .d_i       (link_i),
      .q_o       (sl)
   );

   // Instruction address decode
   bmx_subch_map u_map_ins (
      .addr_i     (wb_dat_i[7:0]),
      .shlog_i    (q.shlog),
      .mode_tab_i (q.mode_tab),
      .valid_o    (iv),
      .shared_o   (ish),
      .idx_o      (iidx),
      .mode_o     (imode)
   );

   // Reconnect address decode
   bmx_subch_map u_map_rec (
      .addr_i     (sl.addr),
      .shlog_i    (q.shlog),
      .mode_tab_i (q.mode_tab),
      .valid_o    (rv),
      .shared_o   (rsh),
      .idx_o      (ridx),
      .mode_o     (rmode)
   );

   // Effective mode of a block-mode subchannel taken at launch and at reconnect
   function automatic bmx_mode_e eff_mode(input bmx_mode_e m, input logic bit0);
      eff_mode = (m == MODE_BLK && !bit0) ? MODE_SEL : m;
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      d        = q;
      d.avail  = 1'b0;
      d.rdat   = 32'h0000_0000;
      d.ack    = wb_cyc_i & wb_stb_i & ~q.ack;
      wr       = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
      wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      chbusy   = (q.st != ST_IDLE);
      ins_go   = wr && (wb_adr_i == REG_INSTR) && (wb_sel_i[1:0] == 2'b11);
      op       = bmx_op_e'(wb_dat_i[INSTR_OP_LSB +: 3]);
      busy_try = ins_go && chbusy && op != OP_NONE && !(op == OP_ABORT && q.mode_bit);
      ce_rise  = sl.chan_end & ~q.ce_prev;
      de_rise  = sl.dev_end & ~q.de_prev;
      d.ce_prev = sl.chan_end;
      d.de_prev = sl.dev_end;
      probe_cc = !iv ? 2'd3 : (q.busy[iidx] ? 2'd2 : 2'd0);

      // Register reads answer with the acknowledge
      if (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i) begin
         case (wb_adr_i)
            REG_CTRL:  d.rdat = {31'h0, q.mode_bit};
            REG_MODES: d.rdat = {16'h0000, q.mode_tab};
            REG_CFG:   d.rdat = {29'h0, q.shlog};
            REG_INSTR,
            REG_STAT:  d.rdat = {26'h0, q.st, q.pend, q.done, q.cc};
            default:   d.rdat = 32'h0000_0000;
         endcase
      end

      // Configuration writes; mode table held apart from mode bit
      if (wr) begin
         case (wb_adr_i)
            REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  d.mode_bit = wb_dat_i[0];
               end
            end
            REG_MODES: begin
               d.mode_tab = (q.mode_tab & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end
            REG_CFG: begin
               if (wb_sel_i[0] && wb_dat_i[2:0] >= SHLOG_MIN && wb_dat_i[2:0] <= SHLOG_MAX) begin
                  d.shlog = wb_dat_i[2:0];
               end
            end
            default: begin
            end
         endcase
      end

      if (initial_program_load_i) begin
         d.mode_bit = 1'b0;
      end

      // Instruction execution
      if (ins_go) begin
         d.done = 1'b1;
         if (busy_try) begin
            d.cc   = 2'd2;
            d.pend = 1'b1;
         end else begin
            case (op)
               OP_LAUNCH: begin
                  if (chbusy) begin
                     d.cc = 2'd2;
                  end else if (!iv) begin
                     d.cc = 2'd3;
                  end else if (q.busy[iidx]) begin
                     d.cc = 2'd2;
                  end else begin
                     d.cc         = 2'd0;
                     d.busy[iidx] = 1'b1;
                     d.cur_idx    = iidx;
                     d.cur_mode   = eff_mode(imode, q.mode_bit);
                     d.st         = ST_FETCH;
                     d.st_req     = 1'b1;
                     d.st_we      = 1'b0;
                     d.st_addr    = SUBCH_BASE + {8'h00, iidx, 2'b00};
                  end
               end
               OP_PROBE: d.cc = probe_cc;
               OP_ABORT: begin
                  if (!q.mode_bit) begin
                     d.cc = probe_cc;
                  end else if (chbusy && q.cur_idx == iidx) begin
                     d.cc = 2'd2;
                  end else if (iv) begin
                     d.cc         = 2'd0;
                     d.busy[iidx] = 1'b0;
                  end else begin
                     d.cc = 2'd3;
                  end
               end
               OP_CHTEST: d.cc = 2'd0;
               OP_HALT: begin
                  d.cc = iv ? 2'd0 : 2'd3;
                  if (iv) begin
                     d.busy[iidx] = 1'b0;
                  end
               end
               default: d.cc = 2'd3;
            endcase
         end
      end

      // ==========================================================
      // Channel sequencer
      case (q.st)
         ST_IDLE: begin
            d.svc = 1'b0;
            if (!ins_go && sl.reconn && rv && q.busy[ridx]) begin
               d.cur_idx  = ridx;
               d.cur_mode = eff_mode(rmode, q.mode_bit);
               d.st       = ST_FETCH;
               d.st_req   = 1'b1;
               d.st_we    = 1'b0;
               d.st_addr  = SUBCH_BASE + {8'h00, ridx, 2'b00};
            end
         end
         ST_FETCH: begin
            if (q.st_req && st_ack_i) begin
               d.unit_control_word    = st_dat_i;
               d.st_req = 1'b0;
               d.pace   = 7'h00;
               d.st     = ST_CONN;
            end
         end
         ST_CONN: begin
            if (q.pace != 7'h00) begin
               d.pace = q.pace - 7'h01;
            end
            if (!sl.data_req) begin
               d.svc = 1'b0;
            end
            if (q.st_req) begin
               if (st_ack_i) begin
                  d.st_req         = 1'b0;
                  d.svc            = 1'b1;
                  d.unit_control_word[31:16]     = q.unit_control_word[31:16] + 16'h0001;
                  d.unit_control_word[15:0]      = q.unit_control_word[15:0] - 16'h0001;
                  d.pace           = PACE_CYC;
               end
            end else if (de_rise) begin
               d.busy[q.cur_idx] = 1'b0;
               d.sv_disc  = 1'b0;
               d.st       = ST_SAVE;
               d.st_req   = 1'b1;
               d.st_we    = 1'b1;
               d.st_addr  = SUBCH_BASE + {8'h00, q.cur_idx, 2'b00};
               d.st_dat   = q.unit_control_word;
            end else if (ce_rise && !sl.dev_end) begin
               if (q.cur_mode == MODE_BLK && sl.disc_ok) begin
                  d.sv_disc = 1'b1;
                  d.st      = ST_SAVE;
                  d.st_req  = 1'b1;
                  d.st_we   = 1'b1;
                  d.st_addr = SUBCH_BASE + {8'h00, q.cur_idx, 2'b00};
                  d.st_dat  = q.unit_control_word;
               end
            end else if (sl.data_req && !q.svc && q.pace == 7'h00) begin
               d.st_req  = 1'b1;
               d.st_we   = 1'b1;
               d.st_addr = q.unit_control_word[31:16];
               d.st_dat  = {24'h00_0000, sl.data};
            end
         end
         ST_SAVE: begin
            if (q.st_req && st_ack_i) begin
               d.st_req = 1'b0;
               d.st_we  = 1'b0;
               d.svc    = 1'b0;
               d.st     = ST_IDLE;
               if (q.sv_disc && q.pend) begin
                  d.avail = 1'b1;
                  // A busy attempt in this very cycle survives the clear
                  d.pend  = busy_try;
               end
            end
         end
         default: d.st = ST_IDLE;
      endcase

      d.hiprio = (d.st == ST_CONN) && (d.cur_mode == MODE_HPC);
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         q          <= '0;
         q.mode_tab <= MODE_TAB_RST;
         q.shlog    <= SHLOG_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign wb_dat_o     = q.rdat;
   assign wb_ack_o     = q.ack;
   assign hiprio_o     = q.hiprio;
   assign chan_avail_o = q.avail;
   assign st_req_o     = q.st_req;
   assign st_we_o      = q.st_we;
   assign st_addr_o    = q.st_addr;
   assign st_dat_o     = q.st_dat;
   assign cu_svc_o     = q.svc;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i || !ce_i);

   sequence fetch_done_s;
      q.st == ST_FETCH && st_req_o && st_ack_i;
   endsequence
   sequence disc_save_s;
      q.st == ST_CONN ##1 (q.st == ST_SAVE && q.sv_disc);
   endsequence

   launch_refuse_a: assert property (ins_go && op == OP_LAUNCH && !chbusy && iv && q.busy[iidx]
      |=> q.cc == 2'd2 && q.st == ST_IDLE) else $error("launch on busy subchannel taken");
   ipl_clear_a: assert property (initial_program_load_i |=> !q.mode_bit)
      else $error("mode bit survived load");
   abort_probe_a: assert property (ins_go && op == OP_ABORT && !q.mode_bit && !chbusy
      |=> $stable(q.busy) && q.cc == $past(probe_cc)) else $error("abort acted with mode bit 0");
   hiprio_mode_a: assert property (hiprio_o |-> q.st == ST_CONN && q.cur_mode == MODE_HPC)
      else $error("priority raised outside chaining");
   sel_no_disc_a: assert property (disc_save_s |-> q.cur_mode == MODE_BLK)
      else $error("non-block subchannel disconnected");
   disc_cause_a: assert property (disc_save_s |-> $past(sl.disc_ok) && $past(ce_rise))
      else $error("disconnect without unit permission");
   avail_disc_a: assert property (chan_avail_o |-> $past(q.st) == ST_SAVE && $past(q.sv_disc)
      && q.st == ST_IDLE) else $error("channel available out of place");
   byte_pace_a: assert property ($rose(cu_svc_o) && q.st == ST_CONN |-> q.pace == PACE_CYC
      ##1 !(st_req_o && st_we_o && q.st == ST_CONN) [*8])
      else $error("bytes closer than the rate allows");
   fetch_bind_a: assert property (fetch_done_s |=> q.st == ST_CONN && q.unit_control_word == $past(st_dat_i))
      else $error("control word not bound on fetch");
   share_cfg_a: assert property (q.shlog >= SHLOG_MIN && q.shlog <= SHLOG_MAX)
      else $error("illegal sharing configuration");
endmodule

// ===== include/bmx_pkg.sv
// Constants, types and carriers shared by the block multiplexer channel files
// Summary of operation
// - At most eight control units share the standard I/O link; a 3-bit unit field.
// - Aggregate transfer rate never exceeds 500 KB/sec; bytes are paced apart. Code paces only within a connection; each fetch clears the pace count.
// - Each subchannel holds one I/O operation; a busy subchannel refuses a launch.
// - Forty subchannels: 32 nonshared plus shared ones, 8x16 or 4x32 as delivered.
// - Shared addresses per subchannel are a multiple of 8; count times size is 128.
// - Every shared subchannel runs selector, block multiplexing or chaining mode.
// - Default mode by upper digit: 8,A,C selector; 9,B,D chaining; E,F block.
// - Selector subchannels never disconnect during a command-chained program.
// - Block mode disconnects only if the unit allows it and the mode bit is set.
// - Chaining mode raises service priority while connected, else acts as selector.
// - At launch the mode bit picks block or selector for block-mode subchannels.
// - Mode bit clears at initial program load; software may change it any time.
// - While the mode bit is zero, abort behaves exactly like probe.
// - Subchannel state lives in storage, fetched into the single unit control word.
// - All data moves by stolen storage cycles, never by program transfers.
// - Channel end without device end disconnects in block mode, keeping state.
// - Device end on a disconnected device reloads state when the channel is free.
// - Disconnect raises channel-available if an instruction met a busy channel.
package bmx_pkg;
   // ==========================================================
   // Timing
   localparam int       CLK_NS       = 25;
   localparam int       BYTE_NS      = 2000;
   localparam logic [6:0] PACE_CYC   = 7'(BYTE_NS / CLK_NS);
   // ==========================================================
   // Geometry
   localparam int       NUM_SUB      = 40;
   localparam logic [15:0] SUBCH_BASE = 16'hF000;
   // ==========================================================
   // Register offsets and fields
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_MODES  = 8'h04;
   localparam logic [7:0] REG_CFG    = 8'h08;
   localparam logic [7:0] REG_INSTR  = 8'h0C;
   localparam logic [7:0] REG_STAT   = 8'h10;
   localparam int       INSTR_OP_LSB = 8;
   localparam int       STAT_CC_LSB  = 0;
   localparam int       STAT_DONE    = 2;
   localparam int       STAT_PEND    = 3;
   localparam int       STAT_ST_LSB  = 4;
   // ==========================================================
   // Reset values and sharing-size limits
   localparam logic [15:0] MODE_TAB_RST = 16'h5888;
   localparam logic [2:0]  SHLOG_RST    = 3'h4;
   localparam logic [2:0]  SHLOG_MIN    = 3'h4;
   localparam logic [2:0]  SHLOG_MAX    = 3'h7;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_SEL = 2'b00,
      MODE_BLK = 2'b01,
      MODE_HPC = 2'b10
   } bmx_mode_e;
   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_LAUNCH = 3'b001,
      OP_PROBE  = 3'b010,
      OP_ABORT  = 3'b011,
      OP_CHTEST = 3'b100,
      OP_HALT   = 3'b101
   } bmx_op_e;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_CONN  = 2'b10,
      ST_SAVE  = 2'b11
   } bmx_state_e;
   typedef struct packed {
      logic       chan_end;
      logic       dev_end;
      logic       disc_ok;
      logic       reconn;
      logic       data_req;
      logic [2:0] unit;
      logic [7:0] addr;
      logic [7:0] data;
   } bmx_link_s;
   typedef struct packed {
      bmx_state_e  st;
      logic        ack;
      logic [31:0] rdat;
      logic        mode_bit;
      logic [15:0] mode_tab;
      logic [2:0]  shlog;
      logic [NUM_SUB-1:0] busy;
      logic [1:0]  cc;
      logic        done;
      logic        pend;
      logic        avail;
      logic [31:0] unit_control_word;
      logic [5:0]  cur_idx;
      bmx_mode_e   cur_mode;
      logic        sv_disc;
      logic        st_req;
      logic        st_we;
      logic [15:0] st_addr;
      logic [31:0] st_dat;
      logic [6:0]  pace;
      logic        svc;
      logic        ce_prev;
      logic        de_prev;
      logic        hiprio;
   } bmx_state_s;
endpackage

// ===== hdl/bmx_sync3.sv
// Three-stage pin synchroniser, output moves once stages two and three agree
module bmx_sync3
   import bmx_pkg::*;
#(
   parameter int W = 24
) (
   // Clock, reset, enable
   input  wire logic         sys_clk_i,
   input  wire logic         reset_n_i,
   input  wire logic         ce_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } bmx_sync_s;

   bmx_sync_s q, d;

   // ==========================================================
   // Shift chain; majority of s2, s3 and held value equals agree-or-hold
   always_comb begin
      d    = q;
      d.s1 = d_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.o  = (q.s2 & q.s3) | (q.o & (q.s2 | q.s3));
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign q_o = q.o;
endmodule

// ===== hdl/bmx_subch_map.sv
// Device address to subchannel index and configured mode decoder
module bmx_subch_map
   import bmx_pkg::*;
(
   // Lookup
   input  wire logic [7:0]  addr_i,
   input  wire logic [2:0]  shlog_i,
   input  wire logic [15:0] mode_tab_i,
   // Result
   output logic             valid_o,
   output logic             shared_o,
   output logic [5:0]       idx_o,
   output bmx_mode_e        mode_o
);
   logic [6:0] sh;
   logic [2:0] k;

   // ==========================================================
   // Nonshared at 20-3F, shared groups of 2^shlog from 80 upward
   // forty subchannel indices
   always_comb begin
      sh       = addr_i[6:0] >> shlog_i;
      k        = sh[2:0];
      valid_o  = 1'b0;
      shared_o = 1'b0;
      idx_o    = 6'h00;
      mode_o   = MODE_SEL;
      if (addr_i[7]) begin
         valid_o  = 1'b1;
         shared_o = 1'b1;
         idx_o    = {3'b100, k};
         case (mode_tab_i[{k, 1'b0} +: 2])
            2'b01:   mode_o = MODE_BLK;
            2'b10:   mode_o = MODE_HPC;
            default: mode_o = MODE_SEL;
         endcase
      end else if (addr_i[7:5] == 3'b001) begin
         valid_o = 1'b1;
         idx_o   = {1'b0, addr_i[4:0]};
         mode_o  = MODE_BLK;
      end
   end
endmodule

// ===== tb/bmx_cu_model.sv
// Control unit link and storage partner for the channel bench
module bmx_cu_model
   import bmx_pkg::*;
(
   // Clock
   input  wire logic        sys_clk_i,
   // Storage port
   input  wire logic        st_req_i,
   input  wire logic        st_we_i,
   input  wire logic [15:0] st_addr_i,
   input  wire logic [31:0] st_dat_i,
   output logic             st_ack_o,
   output logic      [31:0] st_dat_o,
   // Control unit link
   input  wire logic        cu_svc_i,
   output bmx_link_s        link_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0]  wait_q;
   logic        last_we;
   logic [15:0] last_addr;
   logic [31:0] last_dat;
   // ==========================================
   // one unit, no fast lines fitted
   initial begin
      st_ack_o = 1'b0;
      st_dat_o = 32'h0;
      wait_q = 2'h1;
      link_o = '0;
      link_o.data = 8'h5A;
   end
   always @(posedge sys_clk_i) begin
      st_ack_o <= 1'b0;
      st_dat_o <= ~st_dat_o;
      if (st_req_i && !st_ack_o && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else if (st_req_i && !st_ack_o) begin
         st_ack_o <= 1'b1;
         st_dat_o <= {16'($urandom), 16'h00FF};
         last_we <= st_we_i;
         last_addr <= st_addr_i;
         last_dat <= st_dat_i;
         wait_q <= 2'($urandom);
      end
   end
   // Byte offered until taken, line then inverted
   task automatic give_byte(input logic [7:0] b);
      int n;
      n = 0;
      link_o.data <= b;
      link_o.data_req <= 1'b1;
      while (cu_svc_i !== 1'b1 && n < 300) begin
         @(posedge sys_clk_i);
         n++;
      end
      link_o.data_req <= 1'b0;
      link_o.data <= ~b;
      @(posedge sys_clk_i);
   endtask
   task automatic ask_reconn(input logic r, input logic [7:0] a);
      link_o.reconn <= r;
      link_o.addr <= a;
   endtask
   // Ending status levels
   task automatic set_ends(input logic ce, input logic de, input logic ok);
      link_o.chan_end <= ce;
      link_o.dev_end <= de;
      link_o.disc_ok <= ok;
   endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the block multiplexer channel
module tb_top
   import bmx_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic        initial_program_load = 1'b0;
   logic [31:0] wb_q, rq, st_rd, st_wd;
   logic        wb_ack, hiprio, avail, st_req, st_we, st_ack, cu_svc;
   logic [15:0] st_addr;
   bmx_link_s   link;
   int          checks = 0;
   int          n_mismatch = 0;
   // ==========================================
   // Clock
   always #12.5 sys_clk = ~sys_clk;
   bmx_channel u_bmx_channel (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
      .initial_program_load_i(initial_program_load), .hiprio_o(hiprio), .chan_avail_o(avail),
      .st_req_o(st_req), .st_we_o(st_we), .st_addr_o(st_addr),
      .st_dat_o(st_wd), .st_ack_i(st_ack), .st_dat_i(st_rd),
      .link_i(link), .cu_svc_o(cu_svc));
   bmx_cu_model u_bmx_cu_model (
      .sys_clk_i(sys_clk), .st_req_i(st_req), .st_we_i(st_we),
      .st_addr_i(st_addr), .st_dat_i(st_wd), .st_ack_o(st_ack),
      .st_dat_o(st_rd), .cu_svc_i(cu_svc), .link_o(link));
   // ==========================================
   // Compare and bus tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rq = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
      if (n >= 50) n_mismatch++;
   endtask
   task automatic instr(input bmx_op_e op, input logic [7:0] a);
      wb(1'b1, REG_INSTR, {21'h0, op, a});
      wb(1'b0, REG_STAT, 32'h0);
   endtask
   task automatic wait_st(input bmx_state_e s);
      int n;
      n = 0;
      do begin
         wb(1'b0, REG_STAT, 32'h0);
         n++;
      end while (rq[5:4] !== s && n < 40);
      chk("state", 32'(s), 32'(rq[5:4]));
   endtask
   // Expected default mode from the upper address digit
   function automatic logic [1:0] mode_exp(input logic [3:0] d);
      case (d)
         4'h9, 4'hB, 4'hD: return MODE_HPC;
         4'hE, 4'hF: return MODE_BLK;
         default: return MODE_SEL;
      endcase
   endfunction
   function automatic logic [15:0] sub_addr(input logic [7:0] a);
      return SUBCH_BASE + ((16'h20 + 16'((a - 8'h80) >> SHLOG_RST)) << 2);
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================
   // Watchdog
   initial begin
      #(25 * 20000);
      n_mismatch++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      logic [7:0]  a;
      logic [7:0]  b;
      logic [15:0] tab;
      logic [15:0] fa;
      int          n;
      void'($urandom(20897));
      for (int k = 0; k < 8; k++) tab[2*k +: 2] = mode_exp(4'(8 + k));
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      wb(1'b0, REG_MODES, 32'h0);
      chk("modes", 32'(tab), rq);
      wb(1'b1, REG_CFG, 32'h3);
      wb(1'b0, REG_CFG, 32'h0);
      chk("shared size", 32'h4, rq);
      wb(1'b1, REG_CTRL, 32'h1);
      wb(1'b0, REG_CTRL, 32'h0);
      chk("mode bit", 32'h1, rq);
      wb(1'b1, REG_MODES, {16'h0, tab ^ 16'h0003});
      initial_program_load <= 1'b1;
      @(posedge sys_clk);
      initial_program_load <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0);
      chk("mode bit", 32'h0, rq);
      wb(1'b0, REG_MODES, 32'h0);
      chk("modes", {16'h0, tab ^ 16'h0003}, rq);
      // Chaining subchannel: priority, byte steal, no disconnect
      a = 8'h90 + 8'($urandom % 3) * 8'h20 + 8'($urandom % 16);
      fa = sub_addr(a);
      instr(OP_LAUNCH, a);
      wait_st(ST_CONN);
      chk("priority", 32'h1, 32'(hiprio));
      b = 8'($urandom);
      u_bmx_cu_model.give_byte(b);
      chk("byte", {24'h0, b}, u_bmx_cu_model.last_dat & 32'hFF);
      instr(OP_LAUNCH, a ^ 8'h20);
      chk("busy cc", 32'h2, 32'(rq[1:0]));
      u_bmx_cu_model.set_ends(1'b1, 1'b0, 1'b1);
      repeat (10) @(posedge sys_clk);
      wait_st(ST_CONN);
      u_bmx_cu_model.set_ends(1'b1, 1'b1, 1'b1);
      wait_st(ST_IDLE);
      chk("save", {15'h0, 1'b1, fa}, {15'h0, u_bmx_cu_model.last_we, u_bmx_cu_model.last_addr});
      chk("priority", 32'h0, 32'(hiprio));
      chk("service", 32'h0, 32'(cu_svc));
      u_bmx_cu_model.set_ends(1'b0, 1'b0, 1'b0);
      // Block subchannel disconnects with mode bit set
      wb(1'b1, REG_CTRL, 32'h1);
      a = 8'hE0 + 8'($urandom % 32);
      fa = sub_addr(a);
      instr(OP_LAUNCH, a);
      wait_st(ST_CONN);
      instr(OP_PROBE, 8'h20);
      u_bmx_cu_model.set_ends(1'b1, 1'b0, 1'b1);
      n = 0;
      while (avail !== 1'b1 && n < 60) begin
         @(posedge sys_clk);
         n++;
      end
      chk("avail", 32'h1, 32'(avail));
      chk("save", {15'h0, 1'b1, fa}, {15'h0, u_bmx_cu_model.last_we, u_bmx_cu_model.last_addr});
      // Abort acts as probe while mode bit is clear
      wb(1'b1, REG_CTRL, 32'h0);
      instr(OP_ABORT, a);
      chk("abort cc", 32'h2, 32'(rq[1:0]));
      instr(OP_LAUNCH, a);
      chk("still busy", 32'h2, 32'(rq[1:0]));
      // Reconnect the disconnected subchannel, then end it
      u_bmx_cu_model.ask_reconn(1'b1, a);
      wait_st(ST_CONN);
      chk("reload", {15'h0, 1'b0, fa}, {15'h0, u_bmx_cu_model.last_we, u_bmx_cu_model.last_addr});
      u_bmx_cu_model.set_ends(1'b0, 1'b1, 1'b1);
      wait_st(ST_IDLE);
      u_bmx_cu_model.ask_reconn(1'b0, 8'h00);
      instr(OP_PROBE, a);
      chk("probe cc", 32'h0, 32'(rq[1:0]));
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rq);
      tally_and_finish();
   end
endmodule
